/* bench/fpd_host_model.sv */
// ----
// Host processor
// ----
module fpd_host_model (
  input  wire logic             clk,
  input  wire logic [7:0]       dataOut,
  output fpd_pkg::fpd_host_type bus
);
  timeunit 1ns;
  timeprecision 1ps;
  int stuck = 0;
  initial bus = {4'hf, 8'h00};
  // Strobe held 8 clocks so the pin synchroniser sees it; data bus inverted once released
  task automatic access(input logic rd, input logic a0, input logic [7:0] wd, output logic [7:0] q);
    @(posedge clk);
    bus <= {1'b0, !rd, rd, a0, wd};
    repeat (8) @(posedge clk);
    q = dataOut;
    bus <= {3'h7, a0, ~wd};
    repeat (4) @(posedge clk);
  endtask
  // Status polled before every data byte, bounded
  task automatic xfer(input logic rd, input logic [7:0] b, output logic [7:0] q);
    logic [7:0] s;
    int n;
    for (n = 0; n < 100; n++) begin
      access(1'b1, 1'b0, 8'h00, s);
      if (s[7:6] === {1'b1, rd}) break;
    end
    if (n == 100) stuck++;
    access(rd, 1'b1, b, q);
  endtask
endmodule

/* bench/fpd_param_decode_bench.sv */
module fpd_param_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s exp %h got %h", nm, e, g); end end
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  fpd_pkg::fpd_host_type   hostIn;
  fpd_pkg::fpd_exec_type   execIn = {4'h0, 8'h5a, 8'h21, 5'h00};
  fpd_pkg::fpd_params_type params;
  logic [7:0]              dataOut, r;
  logic [1:0]              driveSelect;
  logic                    dataOe, headSelect, headLoad, stepPulse, stepDir, execRun;
  int                      error_cnt = 0, num_checks = 0, stepCnt = 0;
  logic [7:0]              seekTgt [2] = '{8'h03, 8'h64};
  logic [7:0]              seekDrv [2] = '{8'h05, 8'h02};
  int                      seekSteps [2] = '{3, 73};
  fpd_param_decode #(.MS_CYCLES(10)) fpd_param_decode_i (
    .clk(clk), .rst(rst), .hostIn(hostIn), .dataOut(dataOut), .dataOe(dataOe), .execIn(execIn),
    .params(params), .driveSelect(driveSelect), .headSelect(headSelect), .headLoad(headLoad),
    .stepPulse(stepPulse), .stepDir(stepDir), .execRun(execRun));
  fpd_host_model fpd_host_model_i (.clk(clk), .dataOut(dataOut), .bus(hostIn));
  initial forever #5 clk = ~clk;
  // Steps counted here; every seek in this run steps toward a higher cylinder
  always @(posedge clk) begin
    if (stepPulse === 1'b1) begin
      stepCnt <= stepCnt + 1;
      `CHK("dir", 1'b1, stepDir)
    end
    if (fpd_host_model_i.stuck != 0) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] b [9], input int n);
    for (int i = 0; i < n; i++) fpd_host_model_i.xfer(1'b0, b[i], r);
  endtask
  task automatic waitRun(input logic v);
    for (int n = 0; n < 400 && execRun !== v; n++) @(posedge clk);
    if (execRun !== v) begin
      error_cnt++;
      conclude();
    end
  endtask
  // Busy bits polled down, bounded
  task automatic waitIdle();
    int n;
    for (n = 0; n < 200; n++) begin
      fpd_host_model_i.access(1'b1, 1'b0, 8'h00, r);
      if (r[4:0] === 5'h00) break;
    end
    if (n == 200) begin
      `CHK("idle", 5'h00, r[4:0])
      conclude();
    end
  endtask
  task automatic sector(input logic tc);
    @(posedge clk);
    execIn.sectorDone <= 1'b1;
    execIn.terminalCount <= tc;
    @(posedge clk);
    execIn.sectorDone <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic results(input logic [7:0] c);
    logic [7:0] q [7];
    for (int i = 0; i < 7; i++) fpd_host_model_i.xfer(1'b1, 8'h00, q[i]);
    `CHK("st0", 2'b00, q[0][7:6])
    `CHK("st1", 8'h5a, q[1])
    `CHK("st2", 8'h21, q[2])
    `CHK("cyl", c, q[3])
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    fpd_host_model_i.access(1'b1, 1'b0, 8'h00, r);
    `CHK("status", 8'h80, r)
    fpd_host_model_i.access(1'b1, 1'b1, 8'h00, r);
    `CHK("data", 8'h00, r)
    cmd('{0: 8'h03, 1: 8'hf1, 2: 8'h03, default: 8'h00}, 3);
    foreach (seekTgt[i]) begin
      stepCnt = 0;
      cmd('{0: 8'h0f, 1: seekDrv[i], 2: seekTgt[i], default: 8'h00}, 3);
      waitIdle();
      `CHK("drive", seekDrv[i][1:0], driveSelect)
      `CHK("head", seekDrv[i][2], headSelect)
      `CHK("steps", seekSteps[i], stepCnt)
      cmd('{0: 8'h08, default: 8'h00}, 1);
      fpd_host_model_i.xfer(1'b1, 8'h00, r);
      `CHK("seekEnd", 3'b001, r[7:5])
      fpd_host_model_i.xfer(1'b1, 8'h00, r);
      `CHK("pcn", seekTgt[i] > 8'h4c ? 8'h4c : seekTgt[i], r)
    end
    cmd('{8'he6, 8'h01, 8'h02, 8'h00, 8'h01, 8'h00, 8'h02, 8'h1b, 8'h40}, 9);
    waitRun(1'b1);
    `CHK("load", 1'b1, headLoad)
    `CHK("flags", 4'hf, params[69:66])
    `CHK("gap", 8'h1b, params.gapThreeLength)
    `CHK("dtl", 16'h0040, params.bytesPerSector)
    fpd_host_model_i.access(1'b1, 1'b0, 8'h00, r);
    `CHK("nonDma", 1'b1, r[5])
    sector(1'b0);
    `CHK("sector", 8'h02, params.sectorNumber)
    sector(1'b0);
    `CHK("side", 9'h101, {headSelect, params.sectorNumber})
    sector(1'b0);
    `CHK("side1", 8'h02, params.sectorNumber)
    sector(1'b0);
    waitRun(1'b0);
    results(8'h02);
    cmd('{8'h11, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'h05, 8'h0e, 8'h02}, 9);
    waitRun(1'b1);
    `CHK("size", 16'h0100, params.bytesPerSector)
    `CHK("stride", 2'h2, params.scanSectorStride)
    sector(1'b0);
    `CHK("next", 8'h03, params.sectorNumber)
    sector(1'b1);
    waitRun(1'b0);
    results(8'h01);
    conclude();
  end
endmodule

/* bench/fpd_param_decode_chk.sv */
// ----
// Port checks
// ----
module fpd_param_decode_chk #(
  parameter int MS_CYCLES = 10
) (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire fpd_pkg::fpd_host_type   hostIn,
  input wire logic [7:0]              dataOut,
  input wire logic                    dataOe,
  input wire fpd_pkg::fpd_exec_type   execIn,
  input wire fpd_pkg::fpd_params_type params,
  input wire logic [1:0]              driveSelect,
  input wire logic                    headSelect,
  input wire logic                    headLoad,
  input wire logic                    stepPulse,
  input wire logic                    stepDir,
  input wire logic                    execRun
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Last sector reached with no side change pending
  sequence lastDone;
    execRun && execIn.sectorDone && params.sectorNumber == params.lastSectorOnCylinder
      && !(params.bothSidesFlag && !headSelect);
  endsequence
  sequence tcDone;
    execRun && execIn.sectorDone && execIn.terminalCount;
  endsequence
  stepOne_a: assert property (stepPulse |=> !stepPulse) else $error("step pulse too long");
  readOff_a: assert property (hostIn.rdN [*8] |-> !dataOe) else $error("read data left on");
  driveHold_a: assert property (execRun && $past(execRun) |-> $stable(driveSelect)) else $error("drive moved");
  parmHold_a: assert property (execRun && $past(execRun) |-> $stable(params.gapThreeLength)
    && $stable(params.densitySelect)) else $error("fields moved");
  sizeBytes_a: assert property (params.sectorSizeCode inside {[1:3]}
    |-> params.bytesPerSector == (16'h0080 << params.sectorSizeCode[1:0])) else $error("bad size");
  cylRange_a: assert property (params.cylinder <= 8'h4c) else $error("cylinder range");
  eotEnd_a: assert property (lastDone or tcDone |=> !execRun) else $error("no end at last");
  endCause_a: assert property ($fell(execRun) |-> $past(execIn.sectorDone)) else $error("stray end");
endmodule
bind fpd_param_decode fpd_param_decode_chk #(.MS_CYCLES(MS_CYCLES)) fpd_param_decode_chk_i (
  .clk(clk), .rst(rst), .hostIn(hostIn), .dataOut(dataOut), .dataOe(dataOe), .execIn(execIn),
  .params(params), .driveSelect(driveSelect), .headSelect(headSelect), .headLoad(headLoad),
  .stepPulse(stepPulse), .stepDir(stepDir), .execRun(execRun));

/* rtl/fpd_defs.svh */
`ifndef FPD_DEFS_SVH
`define FPD_DEFS_SVH

// ----------------------------------------------------------------
// Host port selection
// ----------------------------------------------------------------
`define FPD_PORT_STATUS   1'b0
`define FPD_PORT_DATA     1'b1

// Main status port bit positions
`define FPD_MSR_RQM       7
`define FPD_MSR_DIO       6
`define FPD_MSR_EXM       5
`define FPD_MSR_BUSY      4

// ----------------------------------------------------------------
// Command codes (low five bits of the first byte)
// ----------------------------------------------------------------
`define FPD_OP_READ_TRACK 5'h02
`define FPD_OP_SPECIFY    5'h03
`define FPD_OP_SENSE_DRV  5'h04
`define FPD_OP_WRITE      5'h05
`define FPD_OP_READ       5'h06
`define FPD_OP_RECAL      5'h07
`define FPD_OP_SENSE_INT  5'h08
`define FPD_OP_WRITE_DEL  5'h09
`define FPD_OP_READ_ID    5'h0a
`define FPD_OP_READ_DEL   5'h0c
`define FPD_OP_FORMAT     5'h0d
`define FPD_OP_SEEK       5'h0f
`define FPD_OP_SCAN_EQ    5'h11
`define FPD_OP_SCAN_LE    5'h19
`define FPD_OP_SCAN_HE    5'h1d

// Flag bit positions in command bytes
`define FPD_BIT_MT        7
`define FPD_BIT_MF        6
`define FPD_BIT_SK        5
`define FPD_BIT_HD        2
`define FPD_BIT_ND        0

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define FPD_ST0_INVALID   8'h80
`define FPD_CYL_MAX       8'h4c
`define FPD_SECTOR_FIRST  8'h01
`define FPD_BASE_BYTES    16'h0080
`define FPD_RST_PINS      12'hfff

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FPD_CLK_NS        10
`define FPD_MS_NS         1000000
`define FPD_MS_CYCLES     (`FPD_MS_NS / `FPD_CLK_NS)
`define FPD_HLT_STEP_MS   2
`define FPD_HUT_STEP_MS   16
`define FPD_SRT_SPAN_MS   16

`endif

/* rtl/fpd_param_decode.sv */
`include "fpd_defs.svh"

// Summary of operation
// R1: Port select low reaches main status port, high reaches data port.
// R2: Cylinder values lie in 0 to 76.
// R3: Host data bus is 8 bits, bit 7 most significant.
// R4: Size code 00 makes short record length the bytes per sector.
// R5: Transfer ends after the sector equal to last sector on cylinder.
// R6: Gap three length sets lock bytes after CRC, or format gap size.
// R7: Head select bit picks head and drives head output; ID head equals it.
// R8: Head load delay 2 to 254 ms in 2 ms steps.
// R9: Head unload delay 16 to 240 ms in 16 ms steps after transfer.
// R10: Density select clear means FM, set means MFM.
// R11: Both sides flag continues at sector 1 side 1 after side 0.
// R12: Step interval 1 to 16 ms, coded reversed, F is 1 ms.
// R13: One step interval serves all drives.
// R14: Seek holds target cylinder and steps toward it.
// R15: Sense interrupt status returns current cylinder.
// R16: Result status bytes offered only in result phase.
// R17: Scan stride 1 compares contiguous sectors, 2 alternate sectors.
// R18: Drive select bits address a drive and drive the select outputs.
// R19: Deleted mark bypass skips deleted-data sectors in read and scan.
// R20: Programmed transfer flag selects non-DMA handshake.
// R21: Size code sets bytes per sector; sector count sets sectors per cylinder.
// R22: Host checks status bits 6 and 7 before each command or result byte.
// R23: Decoded fields stay latched until the result phase ends.
module fpd_param_decode #(
  parameter int MS_CYCLES = `FPD_MS_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire fpd_pkg::fpd_host_type hostIn,
  output logic [7:0]                 dataOut,
  output logic                       dataOe,
  input  wire fpd_pkg::fpd_exec_type execIn,
  output fpd_pkg::fpd_params_type    params,
  output logic [1:0]                 driveSelect,
  output logic                       headSelect,
  output logic                       headLoad,
  output logic                       stepPulse,
  output logic                       stepDir,
  output logic                       execRun
);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic logic isScan(input logic [4:0] op);
    return op inside {`FPD_OP_SCAN_EQ, `FPD_OP_SCAN_LE, `FPD_OP_SCAN_HE};
  endfunction

  function automatic logic isXfer(input logic [4:0] op);
    return isScan(op) || op inside {`FPD_OP_READ, `FPD_OP_WRITE, `FPD_OP_READ_DEL,
                                    `FPD_OP_WRITE_DEL, `FPD_OP_READ_TRACK};
  endfunction

  function automatic logic [3:0] cmdLength(input logic [4:0] op);
    if (isXfer(op)) return 4'h9;
    unique case (op)
      `FPD_OP_SPECIFY, `FPD_OP_SEEK:                      return 4'h3;
      `FPD_OP_SENSE_DRV, `FPD_OP_RECAL, `FPD_OP_READ_ID:  return 4'h2;
      `FPD_OP_FORMAT:                                     return 4'h6;
      default:                                            return 4'h1;
    endcase
  endfunction

  function automatic logic [2:0] resultLength(input logic [4:0] op);
    if (isXfer(op) || op == `FPD_OP_READ_ID || op == `FPD_OP_FORMAT) return 3'h7;
    unique case (op)
      `FPD_OP_SENSE_INT:                                return 3'h2;
      `FPD_OP_SPECIFY, `FPD_OP_SEEK, `FPD_OP_RECAL:     return 3'h0;
      default:                                          return 3'h1;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser, three stages, change taken when last two agree
  // ----------------------------------------------------------------
  localparam int PINS = 12;
  logic [PINS-1:0] sync1_q;
  logic [PINS-1:0] sync2_q;
  logic [PINS-1:0] sync3_q;
  logic [PINS-1:0] pin_q;
  fpd_pkg::fpd_host_type pin;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= `FPD_RST_PINS;
      sync2_q <= `FPD_RST_PINS;
      sync3_q <= `FPD_RST_PINS;
    end else begin
      sync1_q <= hostIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Per-bit agreement filter rejects single-cycle glitches
  for (genvar i = 0; i < PINS; i++) begin : gPin
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pin_q[i] <= 1'b1;
      end else if (sync2_q[i] == sync3_q[i]) begin
        pin_q[i] <= sync3_q[i];
      end
    end
  end
  assign pin = pin_q;

  // ----------------------------------------------------------------
  // Host strobes
  // ----------------------------------------------------------------
  logic       rdPrev_q;
  logic       wrPrev_q;
  logic       rdPort_q;
  logic       wrPort_q;
  logic [7:0] wrData_q;
  wire        rdAct  = ~pin.csN & ~pin.rdN;
  wire        wrAct  = ~pin.csN & ~pin.wrN;
  wire        dataWr = wrPrev_q & ~wrAct & (wrPort_q == `FPD_PORT_DATA);  // [R1]
  wire        dataRd = rdPrev_q & ~rdAct & (rdPort_q == `FPD_PORT_DATA);  // [R1]

  // Data is taken at the trailing edge of the write, after it settled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdPrev_q <= 1'b0;
      wrPrev_q <= 1'b0;
      rdPort_q <= 1'b0;
      wrPort_q <= 1'b0;
      wrData_q <= 8'h00;
    end else begin
      rdPrev_q <= rdAct;
      wrPrev_q <= wrAct;
      if (rdAct) rdPort_q <= pin.portSelectLine;
      if (wrAct) begin
        wrPort_q <= pin.portSelectLine;
        wrData_q <= pin.data;  // [R3]
      end
    end
  end

  // ----------------------------------------------------------------
  // Command byte store and field decode
  // ----------------------------------------------------------------
  fpd_pkg::fpd_phase_type phase_q;
  fpd_pkg::fpd_phase_type phase_d;
  logic [7:0] cmdByte_q [0:8];
  logic [3:0] cmdIdx_q;
  logic [2:0] resIdx_q;

  wire [4:0]  opcode   = cmdByte_q[0][4:0];
  wire [4:0]  firstOp  = (cmdIdx_q == 4'h0) ? wrData_q[4:0] : opcode;
  wire        xferOp   = isXfer(opcode);
  wire        fmtOp    = opcode == `FPD_OP_FORMAT;
  wire        idLikeOp = xferOp | fmtOp | (opcode == `FPD_OP_READ_ID);
  wire        seekOp   = opcode == `FPD_OP_SEEK;
  wire        recalOp  = opcode == `FPD_OP_RECAL;
  wire        sIntOp   = opcode == `FPD_OP_SENSE_INT;
  wire        sDrvOp   = opcode == `FPD_OP_SENSE_DRV;
  wire [2:0]  resLen   = resultLength(opcode);
  wire        mtBit    = cmdByte_q[0][`FPD_BIT_MT];
  wire [7:0]  sizeCode = fmtOp ? cmdByte_q[2] : cmdByte_q[5];
  wire [7:0]  last_sector_on_cylinder      = cmdByte_q[6];
  wire [7:0]  gapLen   = fmtOp ? cmdByte_q[4] : cmdByte_q[7];  // [R6]
  wire [7:0]  short_record_length      = cmdByte_q[8];
  wire [1:0]  stride   = isScan(opcode) ? cmdByte_q[8][1:0] : 2'h1;  // [R17]
  wire [7:0]  newCyl   = seekOp ? cmdByte_q[2] : 8'h00;
  // Short record length only counts when size code is zero
  wire [15:0] bytesPer = (sizeCode == 8'h00) ? {8'h00, short_record_length}
                       : 16'(`FPD_BASE_BYTES << sizeCode[2:0]);  // [R4] [R21]

  // Array is written only while collecting, so fields hold to the end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < 9; k++) cmdByte_q[k] <= 8'h00;
    end else if (phase_q == fpd_pkg::PhCommand && dataWr) begin
      cmdByte_q[cmdIdx_q] <= wrData_q;  // [R23]
    end
  end

  // ----------------------------------------------------------------
  // Phase control
  // ----------------------------------------------------------------
  logic [7:0] cyl_q;
  logic [7:0] sector_q;
  logic       head_q;
  logic [1:0] unit_q;
  logic [7:0] curCyl_q;
  logic [7:0] tgtCyl_q;
  logic [7:0] delayMs_q;
  logic       msTick_q;
  wire        lastSector = (sector_q == last_sector_on_cylinder) & ~(mtBit & ~head_q);
  wire        execEnd    = execIn.sectorDone & (execIn.terminalCount | lastSector | ~xferOp);  // [R5]
  wire        stepEvent  = phase_q == fpd_pkg::PhStep && curCyl_q != tgtCyl_q && delayMs_q == 8'h00;

  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      fpd_pkg::PhCommand:
        if (dataWr && cmdIdx_q + 4'h1 == cmdLength(firstOp)) phase_d = fpd_pkg::PhDecode;
      fpd_pkg::PhDecode:
        if (seekOp || recalOp)             phase_d = fpd_pkg::PhStep;
        else if (idLikeOp)                 phase_d = fpd_pkg::PhLoad;
        else if (resLen == 3'h0)           phase_d = fpd_pkg::PhCommand;
        else                               phase_d = fpd_pkg::PhResult;
      fpd_pkg::PhStep:
        if (curCyl_q == tgtCyl_q)          phase_d = fpd_pkg::PhCommand;
      fpd_pkg::PhLoad:
        if (delayMs_q == 8'h00)            phase_d = fpd_pkg::PhExec;
      fpd_pkg::PhExec:
        if (execEnd)                       phase_d = fpd_pkg::PhResult;
      fpd_pkg::PhResult:
        if (dataRd && resIdx_q + 3'h1 == resLen) phase_d = fpd_pkg::PhCommand;
    endcase
  end

  // Phase and byte counters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q  <= fpd_pkg::PhCommand;
      cmdIdx_q <= 4'h0;
      resIdx_q <= 3'h0;
    end else begin
      phase_q <= phase_d;
      if (phase_q == fpd_pkg::PhCommand && dataWr)
        cmdIdx_q <= (phase_d == fpd_pkg::PhDecode) ? 4'h0 : cmdIdx_q + 4'h1;
      if (phase_q == fpd_pkg::PhDecode) resIdx_q <= 3'h0;
      else if (phase_q == fpd_pkg::PhResult && dataRd) resIdx_q <= resIdx_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Specify settings, shared by every drive
  // ----------------------------------------------------------------
  logic [3:0] stepRate_q;
  logic [3:0] unloadCode_q;
  logic [6:0] loadCode_q;
  logic       noDma_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stepRate_q   <= 4'h0;
      unloadCode_q <= 4'h0;
      loadCode_q   <= 7'h00;
      noDma_q      <= 1'b0;
    end else if (phase_q == fpd_pkg::PhDecode && opcode == `FPD_OP_SPECIFY) begin
      stepRate_q   <= cmdByte_q[1][7:4];  // [R13]
      unloadCode_q <= cmdByte_q[1][3:0];
      loadCode_q   <= cmdByte_q[2][7:1];
      noDma_q      <= cmdByte_q[2][`FPD_BIT_ND];  // [R20]
    end
  end

  // ----------------------------------------------------------------
  // Millisecond timebase and delay counter
  // ----------------------------------------------------------------
  logic [16:0] msCount_q;
  wire  [7:0]  stepMs = 8'(`FPD_SRT_SPAN_MS - int'(stepRate_q));     // [R12]
  wire  [7:0]  loadMs = 8'(`FPD_HLT_STEP_MS * int'(loadCode_q));     // [R8]
  wire  [7:0]  hutMs  = 8'(`FPD_HUT_STEP_MS * int'(unloadCode_q));   // [R9]
  wire         loadGo = phase_q == fpd_pkg::PhDecode && idLikeOp;

  // Delay counts whole ticks, so it may run up to one tick short
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msCount_q <= 17'h00000;
      msTick_q  <= 1'b0;
      delayMs_q <= 8'h00;
    end else begin
      msTick_q  <= msCount_q == 17'(MS_CYCLES - 1);
      msCount_q <= (msCount_q == 17'(MS_CYCLES - 1)) ? 17'h00000 : msCount_q + 17'h00001;
      if (loadGo) delayMs_q <= headLoad ? 8'h00 : loadMs;  // [R8]
      else if (stepEvent) delayMs_q <= stepMs;  // [R12]
      else if (msTick_q && delayMs_q != 8'h00) delayMs_q <= delayMs_q - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Seek stepping and cylinder tracking
  // ----------------------------------------------------------------
  logic seekEnd_q;
  wire  seekDone = phase_q == fpd_pkg::PhStep && curCyl_q == tgtCyl_q;
  wire  seekClr  = phase_q == fpd_pkg::PhResult && sIntOp && dataRd;  // Cleared once read

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      curCyl_q  <= 8'h00;
      tgtCyl_q  <= 8'h00;
      stepPulse <= 1'b0;
      stepDir   <= 1'b0;
      seekEnd_q <= 1'b0;
    end else begin
      // Out-of-range targets are pinned to the last cylinder
      if (phase_q == fpd_pkg::PhDecode && (seekOp || recalOp))
        tgtCyl_q <= (newCyl > `FPD_CYL_MAX) ? `FPD_CYL_MAX : newCyl;  // [R2] [R14]
      stepPulse <= stepEvent;
      if (stepEvent) begin
        stepDir  <= tgtCyl_q > curCyl_q;
        curCyl_q <= (tgtCyl_q > curCyl_q) ? curCyl_q + 8'h01 : curCyl_q - 8'h01;  // [R14]
      end
      seekEnd_q <= seekDone | (seekEnd_q & ~seekClr);
    end
  end

  // ----------------------------------------------------------------
  // Sector sequencing during execution
  // ----------------------------------------------------------------
  logic [1:0] endCode_q;
  logic [7:0] st1_q;
  logic [7:0] st2_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyl_q     <= 8'h00;
      sector_q  <= 8'h00;
      head_q    <= 1'b0;
      unit_q    <= 2'h0;
      endCode_q <= 2'h0;
      st1_q     <= 8'h00;
      st2_q     <= 8'h00;
    end else if (phase_q == fpd_pkg::PhDecode) begin
      unit_q   <= cmdByte_q[1][1:0];  // [R18]
      head_q   <= cmdByte_q[1][`FPD_BIT_HD];  // [R7]
      cyl_q    <= (cmdByte_q[2] > `FPD_CYL_MAX) ? `FPD_CYL_MAX : cmdByte_q[2];  // [R2]
      sector_q <= cmdByte_q[4];
    end else if (phase_q == fpd_pkg::PhExec && execIn.sectorDone) begin
      if (execEnd) begin
        endCode_q <= execIn.endCode;
        st1_q     <= execIn.resultStatusB;
        st2_q     <= execIn.resultStatusC;
      end else if (sector_q == last_sector_on_cylinder) begin
        head_q   <= 1'b1;  // [R11]
        sector_q <= `FPD_SECTOR_FIRST;  // [R11]
      end else begin
        sector_q <= sector_q + {6'h00, stride};  // [R17]
      end
    end
  end

  // ----------------------------------------------------------------
  // Head load and unload
  // ----------------------------------------------------------------
  logic [7:0] unloadMs_q;
  logic       unloadArm_q;
  wire        execStop = phase_q == fpd_pkg::PhExec && execEnd;

  // Head stays loaded across back-to-back transfers to save the load delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      headLoad    <= 1'b0;
      unloadArm_q <= 1'b0;
      unloadMs_q  <= 8'h00;
    end else if (loadGo) begin
      headLoad    <= 1'b1;
      unloadArm_q <= 1'b0;
    end else if (execStop) begin
      unloadArm_q <= 1'b1;
      unloadMs_q  <= hutMs;  // [R9]
    end else if (unloadArm_q) begin
      if (unloadMs_q == 8'h00) begin
        headLoad    <= 1'b0;  // [R9]
        unloadArm_q <= 1'b0;
      end else if (msTick_q) begin
        unloadMs_q <= unloadMs_q - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result bytes and host read data
  // ----------------------------------------------------------------
  wire [7:0] st0Xfer = {endCode_q, 3'h0, head_q, unit_q};
  wire [7:0] st0Int  = {2'h0, seekEnd_q, 2'h0, head_q, unit_q};
  wire [7:0] st3     = {execIn.driveState, cmdByte_q[1][`FPD_BIT_HD], cmdByte_q[1][1:0]};
  wire [7:0] xferRes [0:6];
  assign xferRes = '{st0Xfer, st1_q, st2_q, cyl_q, {7'h00, head_q}, sector_q, sizeCode};  // [R7]

  wire [7:0] resByte = sIntOp   ? ((resIdx_q == 3'h0) ? st0Int : curCyl_q)  // [R15]
                     : sDrvOp   ? st3
                     : idLikeOp ? xferRes[resIdx_q]
                     : `FPD_ST0_INVALID;
  wire       inResult = phase_q == fpd_pkg::PhResult;
  wire [7:0] dataByte = inResult ? resByte : 8'h00;  // [R16]
  wire       rqm      = phase_q == fpd_pkg::PhCommand || inResult;  // [R22]
  wire       busyBit  = phase_q != fpd_pkg::PhCommand || cmdIdx_q != 4'h0;
  wire [3:0] driveBsy = (phase_q == fpd_pkg::PhStep) ? 4'(4'h1 << unit_q) : 4'h0;
  wire [7:0] main_status_port      = {rqm, inResult, phase_q == fpd_pkg::PhExec && noDma_q, busyBit, driveBsy};

  // Read data is refreshed every cycle so it follows the latest state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dataOut <= 8'h00;
      dataOe  <= 1'b0;
    end else begin
      dataOut <= (pin.portSelectLine == `FPD_PORT_STATUS) ? main_status_port : dataByte;  // [R1]
      dataOe  <= rdAct;
    end
  end

  // ----------------------------------------------------------------
  // Registered drive and parameter outputs
  // ----------------------------------------------------------------
  fpd_pkg::fpd_params_type paramsD;
  assign paramsD = '{
    bothSidesFlag:          mtBit,
    densitySelect:          cmdByte_q[0][`FPD_BIT_MF],  // [R10]
    deletedMarkBypass:      cmdByte_q[0][`FPD_BIT_SK],  // [R19]
    programmedTransferFlag: noDma_q,
    sectorSizeCode:         sizeCode,
    lastSectorOnCylinder:   last_sector_on_cylinder,
    gapThreeLength:         gapLen,
    sectorsPerCylinder:     cmdByte_q[3],  // [R21]
    scanSectorStride:       stride,
    bytesPerSector:         bytesPer,
    cylinder:               cyl_q,
    sectorNumber:           sector_q
  };

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      params      <= '0;
      driveSelect <= 2'h0;
      headSelect  <= 1'b0;
      execRun     <= 1'b0;
    end else begin
      params      <= paramsD;
      driveSelect <= unit_q;  // [R18]
      headSelect  <= head_q;  // [R7]
      execRun     <= phase_d == fpd_pkg::PhExec;
    end
  end

endmodule

/* rtl/fpd_pkg.sv */
package fpd_pkg;

  // ----------------------------------------------------------------
  // Controller phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PhCommand,
    PhDecode,
    PhStep,
    PhLoad,
    PhExec,
    PhResult
  } fpd_phase_type;

  // Host bus pins as seen at the device
  typedef struct packed {
    logic       csN;
    logic       rdN;
    logic       wrN;
    logic       portSelectLine;
    logic [7:0] data;
  } fpd_host_type;

  // Reports from the data path during execution
  typedef struct packed {
    logic       sectorDone;
    logic       terminalCount;
    logic [1:0] endCode;
    logic [7:0] resultStatusB;
    logic [7:0] resultStatusC;
    logic [4:0] driveState;
  } fpd_exec_type;

  // Decoded parameters handed to the data path
  typedef struct packed {
    logic        bothSidesFlag;
    logic        densitySelect;
    logic        deletedMarkBypass;
    logic        programmedTransferFlag;
    logic [7:0]  sectorSizeCode;
    logic [7:0]  lastSectorOnCylinder;
    logic [7:0]  gapThreeLength;
    logic [7:0]  sectorsPerCylinder;
    logic [1:0]  scanSectorStride;
    logic [15:0] bytesPerSector;
    logic [7:0]  cylinder;
    logic [7:0]  sectorNumber;
  } fpd_params_type;

endpackage
